// file: reset_strap_config_loader.sv
`timescale 1ns/10ps
`include "reset_strap_regs.svh"
module reset_strap_config_loader #(
	parameter logic [15:0] IO_BASE = `IO_BASE_DEFAULT
) (
	// Clock, global reset and enable
	input  logic                 clk_sys,
	input  logic                 reset,
	input  logic                 clkEnable,
	// Strap pins and processor reset
	input  logic [31:0]          localMemoryDataIn,
	input  logic                 processorResetN,
	// Configuration access
	input  logic                 cfgValid,
	input  logic                 cfgWrite,
	input  logic                 cfgDevice,
	input  logic [7:0]           cfgOffset,
	input  logic [31:0]          cfgWriteData,
	// Memory access
	input  logic                 memValid,
	input  logic                 memWrite,
	input  logic [31:0]          memAddr,
	input  logic [31:0]          memWriteData,
	// I/O access
	input  logic                 ioValid,
	input  logic                 ioWrite,
	input  logic [15:0]          ioAddr,
	input  logic [31:0]          ioWriteData,
	// Access answer
	output logic                 rspValid,
	output logic [31:0]          rspData,
	// Display cache clocks and data
	output logic                 cacheTransmitClock,
	output logic                 cacheLoopOutClock,
	output logic                 cacheClockOeN,
	input  logic                 cacheReceiveClock,
	input  logic [31:0]          cacheDataIn,
	// Latched options
	output logic                 xorTestMode,
	output logic                 xorChainOut,
	output strap_pkg::host_freq_t hostFrequency,
	output logic [2:0]           inOrderQueueDepth
);
	import strap_pkg::*;

	localparam int WB = `MMIO_WINDOW_BITS;

	strap_if    straps ();
	top_state_t s;
	top_state_t n;

	strap_latch u_strap_latch (
		.clk_sys           (clk_sys),
		.reset             (reset),
		.clkEnable         (clkEnable),
		.localMemoryDataIn (localMemoryDataIn),
		.processorResetN   (processorResetN),
		.straps            (straps.producer)
	);

	// Address falls in the graphics memory window
	function automatic logic memHit(input logic [31:0] addr, input logic [31:0] base);
		return addr[31:WB] == base[31:WB];
	endfunction

	// I/O address falls in the diagnostic block
	function automatic logic ioHit(input logic [15:0] addr);
		return addr[15:4] == IO_BASE[15:4];
	endfunction

	// Next state: clocks, capture, straps test logic and register access
	always_comb begin
		n = s;
		n.rspValid = 1'b0;
		n.rxPrev   = cacheReceiveClock;
		// Tri-state only while in reset with the strap set
		n.oeN    = reset && straps.allZ;
		n.xorOut = straps.xorTest && (^localMemoryDataIn);
		// Transmit and loop-out clocks divide the system clock by two
		if (s.cacheCtrl[`CACHE_CTRL_CLK_EN_BIT]) begin
			n.txClk   = ~s.txClk;
			n.loopClk = ~s.txClk;
		end
		// Data from the cache comes in on the returned receive clock
		if (cacheReceiveClock && !s.rxPrev) begin
			n.diagCapture = cacheDataIn;
		end
		// Configuration wins over memory, memory over I/O
		if (cfgValid) begin
			n.rspValid = 1'b1;
			n.rspData  = 32'h0000_0000;
			if (cfgDevice == `CFG_DEV_GRAPHICS && cfgOffset == `CFG_OFF_MMIO_BASE) begin
				if (cfgWrite) begin
					n.mmioBase = {cfgWriteData[31:WB], {WB{1'b0}}};
				end else begin
					n.rspData = s.mmioBase;
				end
			end else if (cfgDevice == `CFG_DEV_BRIDGE && cfgOffset == `CFG_OFF_STRAP_STATUS
				&& !cfgWrite) begin
				n.rspData = {straps.xorTest, straps.allZ, 1'b0, straps.queueOne,
					26'h000_0000, straps.hostFreq};
			end
		end else if (memValid) begin
			n.rspValid = 1'b1;
			n.rspData  = 32'h0000_0000;
			if (memHit(memAddr, s.mmioBase)) begin
				case (memAddr[WB-1:0])
					`MEM_OFF_CACHE_CTRL: begin
						if (memWrite) begin
							n.cacheCtrl = memWriteData;
						end else begin
							n.rspData = s.cacheCtrl;
						end
					end
					`MEM_OFF_DIAG_DATA: begin
						if (memWrite) begin
							n.diagData = memWriteData;
						end else begin
							n.rspData = s.diagData;
						end
					end
					`MEM_OFF_DIAG_CAPTURE: begin
						if (!memWrite) begin
							n.rspData = s.diagCapture;
						end
					end
					default: begin
						n.rspData = 32'h0000_0000;
					end
				endcase
			end
		end else if (ioValid) begin
			n.rspValid = 1'b1;
			n.rspData  = 32'h0000_0000;
			if (ioHit(ioAddr)) begin
				case (ioAddr[3:0])
					`IO_OFF_DIAG_DATA: begin
						if (ioWrite) begin
							n.diagData = ioWriteData;
						end else begin
							n.rspData = s.diagData;
						end
					end
					`IO_OFF_DIAG_CAPTURE: begin
						if (!ioWrite) begin
							n.rspData = s.diagCapture;
						end
					end
					default: begin
						n.rspData = 32'h0000_0000;
					end
				endcase
			end
		end
		// Global reset returns every register except rxPrev and oeN to its default
		if (reset) begin
			n.txClk       = 1'b0;
			n.loopClk     = 1'b0;
			n.xorOut      = 1'b0;
			n.mmioBase    = `MMIO_BASE_RESET;
			n.cacheCtrl   = `CACHE_CTRL_RESET;
			n.diagData    = `DIAG_RESET;
			n.diagCapture = `DIAG_RESET;
			n.rspValid    = 1'b0;
			n.rspData     = 32'h0000_0000;
		end
	end

	// Reset acts even while the clock enable is low
	always_ff @(posedge clk_sys) begin
		if (reset || clkEnable) begin
			s <= n;
		end
	end

	// Outputs
	assign rspValid           = s.rspValid;
	assign rspData            = s.rspData;
	assign cacheTransmitClock = s.txClk;
	assign cacheLoopOutClock  = s.loopClk;
	assign cacheClockOeN      = s.oeN;
	assign xorTestMode        = straps.xorTest;
	assign xorChainOut        = s.xorOut;
	assign hostFrequency      = straps.hostFreq;
	assign inOrderQueueDepth  = straps.queueOne ? 3'h1 : 3'h4;

	// Transmit clock toggles every enabled cycle
	a_tx_clock_toggle: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEnable && s.cacheCtrl[`CACHE_CTRL_CLK_EN_BIT]) |=> (s.txClk != $past(s.txClk)))
		else $error("transmit clock did not toggle");

	// Loop-out clock runs in step with the transmit clock
	a_loop_clock_match: assert property (@(posedge clk_sys) disable iff (reset)
		s.loopClk == s.txClk)
		else $error("loop-out clock out of step");

	// Memory read of cache control through the graphics base
	a_mmio_ctrl_read: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEnable && !cfgValid && memValid && !memWrite && memHit(memAddr, s.mmioBase)
			&& memAddr[WB-1:0] == `MEM_OFF_CACHE_CTRL)
			|=> rspValid && (rspData == $past(s.cacheCtrl)))
		else $error("cache control read through window failed");

	// Diagnostic data written by I/O reads back through memory
	a_diag_io_to_mem: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEnable && !cfgValid && !memValid && ioValid && ioWrite && ioHit(ioAddr)
			&& ioAddr[3:0] == `IO_OFF_DIAG_DATA)
			|=> (s.diagData == $past(ioWriteData)))
		else $error("diagnostic write through I/O lost");

	// Graphics function returns its base at offset 14h
	a_cfg_graphics_base: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEnable && cfgValid && !cfgWrite && cfgDevice == `CFG_DEV_GRAPHICS
			&& cfgOffset == `CFG_OFF_MMIO_BASE)
			|=> rspValid && (rspData == $past(s.mmioBase)))
		else $error("graphics base read wrong");

	// Outputs driven once reset has gone
	a_outputs_enabled: assert property (@(posedge clk_sys) disable iff (reset)
		(!$past(reset) && $past(clkEnable)) |-> !cacheClockOeN)
		else $error("outputs tri-stated outside reset");

endmodule

// file: reset_strap_regs.svh
`ifndef RESET_STRAP_REGS_SVH
`define RESET_STRAP_REGS_SVH

// Configuration space offsets
`define CFG_OFF_STRAP_STATUS   8'h50
`define CFG_OFF_MMIO_BASE      8'h14
`define CFG_DEV_BRIDGE         1'b0
`define CFG_DEV_GRAPHICS       1'b1

// Memory space offsets from the graphics base
`define MEM_OFF_CACHE_CTRL     19'h0_3000
`define MEM_OFF_DIAG_DATA      19'h0_3004
`define MEM_OFF_DIAG_CAPTURE   19'h0_3008
`define MMIO_WINDOW_BITS       19

// I/O space offsets from the I/O base
`define IO_OFF_DIAG_DATA       4'h0
`define IO_OFF_DIAG_CAPTURE    4'h4
`define IO_BASE_DEFAULT        16'h0400

// Strap bit positions on the local memory data pins
`define STRAP_XOR_BIT          31
`define STRAP_ALLZ_BIT         30
`define STRAP_FREQ_BIT         29
`define STRAP_QUEUE_BIT        28
`define STRAP_FAST_BIT         13

// Register fields and reset values
`define CACHE_CTRL_CLK_EN_BIT  0
`define MMIO_BASE_RESET        32'h0000_0000
`define CACHE_CTRL_RESET       32'h0000_0001
`define DIAG_RESET             32'h0000_0000

`endif

// file: strap_pkg.sv
package strap_pkg;

	typedef enum logic [1:0] {
		HOST_FREQ_66  = 2'b00,
		HOST_FREQ_100 = 2'b01,
		HOST_FREQ_133 = 2'b10
	} host_freq_t;

	typedef enum logic [1:0] {
		PH_COLD     = 2'b00,
		PH_WAIT_CPU = 2'b01,
		PH_RUN      = 2'b10
	} phase_t;

	typedef struct packed {
		phase_t     phase;
		logic       xorTest;
		logic       allZ;
		host_freq_t hostFreq;
		logic       queueOne;
		logic       procResetPrev;
	} strap_state_t;

	typedef struct packed {
		logic        txClk;
		logic        loopClk;
		logic        oeN;
		logic        xorOut;
		logic        rxPrev;
		logic [31:0] mmioBase;
		logic [31:0] cacheCtrl;
		logic [31:0] diagData;
		logic [31:0] diagCapture;
		logic        rspValid;
		logic [31:0] rspData;
	} top_state_t;

	// Bit 13 forces the fast bus, otherwise bit 29 picks between the two slower ones
	function automatic host_freq_t decodeFrequency(input logic fast, input logic mid);
		if (fast) begin
			return HOST_FREQ_133;
		end
		return mid ? HOST_FREQ_100 : HOST_FREQ_66;
	endfunction

endpackage

// file: strap_if.sv
`timescale 1ns/10ps
interface strap_if;
	import strap_pkg::*;
	phase_t     phase;
	logic       xorTest;
	logic       allZ;
	host_freq_t hostFreq;
	logic       queueOne;

	modport producer (output phase, output xorTest, output allZ, output hostFreq,
		output queueOne);
	modport consumer (input phase, input xorTest, input allZ, input hostFreq,
		input queueOne);
endinterface

// file: strap_latch.sv
`timescale 1ns/10ps
`include "reset_strap_regs.svh"
module strap_latch (
	// Clock, reset and enable
	input  logic                 clk_sys,
	input  logic                 reset,
	input  logic                 clkEnable,
	// Strap pins
	input  logic [31:0]          localMemoryDataIn,
	input  logic                 processorResetN,
	// Latched options
	strap_if.producer            straps
);
	import strap_pkg::*;

	strap_state_t s;
	strap_state_t n;

	// Sample test, tri-state and frequency straps throughout cold reset, then hold them
	always_comb begin
		n = s;
		n.procResetPrev = processorResetN;
		if (reset) begin
			n.phase    = PH_COLD;
			n.xorTest  = localMemoryDataIn[`STRAP_XOR_BIT];
			n.allZ     = localMemoryDataIn[`STRAP_ALLZ_BIT];
			n.hostFreq = decodeFrequency(localMemoryDataIn[`STRAP_FAST_BIT],
				localMemoryDataIn[`STRAP_FREQ_BIT]);
			n.queueOne = 1'b0;
		end else begin
			case (s.phase)
				PH_COLD, PH_WAIT_CPU: begin
					n.phase = PH_WAIT_CPU;
					// Queue depth taken once, on the processor reset release
					if (processorResetN && !s.procResetPrev) begin
						n.queueOne = localMemoryDataIn[`STRAP_QUEUE_BIT];
						n.phase    = PH_RUN;
					end
				end
				PH_RUN: begin
					n.phase = PH_RUN;
				end
				default: begin
					n.phase = PH_COLD;
				end
			endcase
		end
	end

	// Reset acts even while the clock enable is low
	always_ff @(posedge clk_sys) begin
		if (reset || clkEnable) begin
			s <= n;
		end
	end

	assign straps.phase    = s.phase;
	assign straps.xorTest  = s.xorTest;
	assign straps.allZ     = s.allZ;
	assign straps.hostFreq = s.hostFreq;
	assign straps.queueOne = s.queueOne;

	// Test and tri-state straps hold the last value seen in reset
	a_test_straps_capture: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(reset) |-> (s.xorTest == $past(localMemoryDataIn[`STRAP_XOR_BIT]))
			&& (s.allZ == $past(localMemoryDataIn[`STRAP_ALLZ_BIT])))
		else $error("test straps not captured at reset release");

	// Frequency follows the two-strap table
	a_freq_decode: assert property (@(posedge clk_sys) disable iff (reset)
		$fell(reset) |-> s.hostFreq == decodeFrequency(
			$past(localMemoryDataIn[`STRAP_FAST_BIT]), $past(localMemoryDataIn[`STRAP_FREQ_BIT])))
		else $error("host frequency decode wrong");

	// Queue depth strap taken on processor reset rising edge
	a_queue_capture: assert property (@(posedge clk_sys) disable iff (reset)
		(clkEnable && s.phase != PH_RUN && processorResetN && !s.procResetPrev)
			|=> (s.phase == PH_RUN) && (s.queueOne == $past(localMemoryDataIn[`STRAP_QUEUE_BIT])))
		else $error("queue depth strap not captured");

	// Test, tri-state and frequency straps frozen outside cold reset
	a_strap_hold: assert property (@(posedge clk_sys) disable iff (reset)
		!$fell(reset) |-> $stable(s.xorTest) && $stable(s.allZ) && $stable(s.hostFreq))
		else $error("strap changed after reset");

	// Once running the queue depth never changes
	a_queue_hold: assert property (@(posedge clk_sys) disable iff (reset)
		(s.phase == PH_RUN) |=> (s.phase == PH_RUN) && $stable(s.queueOne))
		else $error("queue depth changed after capture");

endmodule

// file: strap_board.sv
`timescale 1ns/10ps
module strap_board (
	// Hub side
	input  logic        pciBusResetN,
	// Resistor settings chosen by the bench
	input  logic [31:0] strapValue,
	input  logic        xorHold,
	// Device pins
	output logic        reset,
	output logic [31:0] localMemoryDataIn
);
	// Hub holds global reset for as long as its bus reset is low
	assign reset = ~pciBusResetN;
	// Resistors set the pins; the fixture keeps bit 31 high while chaining
	assign localMemoryDataIn = xorHold ? (strapValue | 32'h8000_0000) : strapValue;
endmodule

// file: tb_reset_strap_config_loader.sv
`timescale 1ns/10ps
`include "reset_strap_regs.svh"
module tb_reset_strap_config_loader;
	import strap_pkg::*;
	// Addresses used by the scenarios
	localparam logic [31:0] BASE   = 32'h0008_0000;
	localparam logic [31:0] CSTAT  = {23'h00_0000, `CFG_DEV_BRIDGE, `CFG_OFF_STRAP_STATUS};
	localparam logic [31:0] CBASE  = {23'h00_0000, `CFG_DEV_GRAPHICS, `CFG_OFF_MMIO_BASE};
	localparam logic [31:0] MCTRL  = BASE | {13'h0000, `MEM_OFF_CACHE_CTRL};
	localparam logic [31:0] MDIAG  = BASE | {13'h0000, `MEM_OFF_DIAG_DATA};
	localparam logic [31:0] MCAP   = BASE | {13'h0000, `MEM_OFF_DIAG_CAPTURE};
	localparam logic [31:0] IODIAG = {16'h0000, `IO_BASE_DEFAULT | 16'h0000};
	localparam logic [31:0] IOCAP  = {16'h0000, `IO_BASE_DEFAULT | 16'h0004};
	// Bench signals
	logic        clk_sys, reset, pciBusResetN, processorResetN, xorHold;
	logic        cfgValid, cfgWrite, cfgDevice, memValid, memWrite, ioValid, ioWrite;
	logic        rspValid, cacheTransmitClock, cacheLoopOutClock, cacheClockOeN;
	logic        cacheReceiveClock, xorTestMode, xorChainOut, t0, clkEnable;
	logic [7:0]  cfgOffset;
	logic [15:0] ioAddr;
	logic [31:0] strapValue, localMemoryDataIn, cfgWriteData, memAddr, memWriteData;
	logic [31:0] ioWriteData, rspData, cacheDataIn, rd;
	logic [2:0]  inOrderQueueDepth;
	host_freq_t  hostFrequency;
	int          fails, cmp_count, cycles;

	strap_board i_board (.pciBusResetN(pciBusResetN), .strapValue(strapValue),
		.xorHold(xorHold), .reset(reset), .localMemoryDataIn(localMemoryDataIn));
	reset_strap_config_loader i_dut (.clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable),
		.localMemoryDataIn(localMemoryDataIn), .processorResetN(processorResetN),
		.cfgValid(cfgValid), .cfgWrite(cfgWrite), .cfgDevice(cfgDevice),
		.cfgOffset(cfgOffset), .cfgWriteData(cfgWriteData), .memValid(memValid),
		.memWrite(memWrite), .memAddr(memAddr), .memWriteData(memWriteData),
		.ioValid(ioValid), .ioWrite(ioWrite), .ioAddr(ioAddr), .ioWriteData(ioWriteData),
		.rspValid(rspValid), .rspData(rspData), .cacheTransmitClock(cacheTransmitClock),
		.cacheLoopOutClock(cacheLoopOutClock), .cacheClockOeN(cacheClockOeN),
		.cacheReceiveClock(cacheReceiveClock), .cacheDataIn(cacheDataIn),
		.xorTestMode(xorTestMode), .xorChainOut(xorChainOut),
		.hostFrequency(hostFrequency), .inOrderQueueDepth(inOrderQueueDepth));

	// 25 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// Cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One request on the chosen space (0 cfg, 1 mem, 2 io); answer lands in rd
	task automatic access(input int kind, input logic wr, input logic [31:0] a,
			input logic [31:0] d);
		int k;
		@(negedge clk_sys);
		cfgValid = (kind == 0);
		memValid = (kind == 1);
		ioValid = (kind == 2);
		cfgWrite = wr;
		memWrite = wr;
		ioWrite = wr;
		cfgDevice = a[8];
		cfgOffset = a[7:0];
		memAddr = a;
		ioAddr = a[15:0];
		cfgWriteData = d;
		memWriteData = d;
		ioWriteData = d;
		@(negedge clk_sys);
		cfgValid = 1'b0;
		memValid = 1'b0;
		ioValid = 1'b0;
		k = 0;
		while (rspValid !== 1'b1 && k < 4) begin
			@(negedge clk_sys);
			k++;
		end
		chk(k < 4, 1'b1);
		rd = rspData;
	endtask

	// Cold reset with the given straps held for ten cycles
	task automatic coldReset(input logic [31:0] s, input logic h);
		@(negedge clk_sys);
		strapValue = s;
		xorHold = h;
		pciBusResetN = 1'b0;
		processorResetN = 1'b0;
		repeat (10) @(negedge clk_sys);
		chk(cacheClockOeN, s[30]);
		pciBusResetN = 1'b1;
		@(negedge clk_sys);
		chk(cacheClockOeN, 1'b0);
	endtask

	// Every frequency pair; pins inverted after reset must not leak in
	task automatic test_freq();
		logic [31:0] s;
		host_freq_t  f;
		for (int i = 0; i < 4; i++) begin
			s = 32'h1000_0000 | {1'b0, i[0] ^ i[1], i[0], 15'h0000, i[1], 13'h0000};
			f = i[1] ? HOST_FREQ_133 : (i[0] ? HOST_FREQ_100 : HOST_FREQ_66);
			coldReset(s, 1'b0);
			strapValue = ~s;
			repeat (2) @(negedge clk_sys);
			chk(hostFrequency, f);
			chk(xorTestMode, 1'b0);
			chk(xorChainOut, 1'b0);
			chk(inOrderQueueDepth, 3'h4);
			access(0, 1'b0, CSTAT, 32'h0000_0000);
			chk(rd, {1'b0, s[30], 28'h000_0000, f});
		end
	endtask

	// Queue depth taken once at the processor reset rise
	task automatic test_queue();
		coldReset(32'h0000_0000, 1'b0);
		strapValue = 32'h1000_0000;
		repeat (2) @(negedge clk_sys);
		chk(inOrderQueueDepth, 3'h4);
		processorResetN = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk(inOrderQueueDepth, 3'h1);
		strapValue = 32'h0000_0000;
		processorResetN = 1'b0;
		repeat (2) @(negedge clk_sys);
		processorResetN = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk(inOrderQueueDepth, 3'h1);
		access(0, 1'b0, CSTAT, 32'h0000_0000);
		chk(rd[28], 1'b1);
	endtask

	// XOR chain follows the two low pins while the fixture holds bit 31
	task automatic test_xor();
		coldReset(32'h8000_0000, 1'b1);
		chk(xorTestMode, 1'b1);
		for (int j = 1; j < 4; j++) begin
			strapValue = j;
			repeat (3) @(negedge clk_sys);
			chk(xorChainOut, ^(strapValue | 32'h8000_0000));
		end
	endtask

	// Base decode, both spaces, read-only and missed places
	task automatic test_regs();
		coldReset(32'h0000_0000, 1'b0);
		access(0, 1'b1, CBASE, 32'h0008_1234);
		access(0, 1'b0, CBASE, 32'h0000_0000);
		chk(rd, BASE);
		access(1, 1'b1, MDIAG, 32'hA5A5_0001);
		access(2, 1'b0, IODIAG, 32'h0000_0000);
		chk(rd, 32'hA5A5_0001);
		access(2, 1'b1, IODIAG, 32'h5A5A_0002);
		access(1, 1'b0, MDIAG, 32'h0000_0000);
		chk(rd, 32'h5A5A_0002);
		access(1, 1'b1, MCAP, 32'hFFFF_FFFF);
		access(1, 1'b0, MCAP, 32'h0000_0000);
		chk(rd, `DIAG_RESET);
		access(1, 1'b0, 32'h0000_3004, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		access(2, 1'b0, 32'h0000_0800, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
	endtask

	// Cache clocks run, loop back, capture data, then stop
	task automatic test_clocks();
		@(negedge clk_sys);
		t0 = cacheTransmitClock;
		@(negedge clk_sys);
		chk(cacheTransmitClock, !t0);
		chk(cacheLoopOutClock, cacheTransmitClock);
		// Enable low freezes the cache clocks
		t0 = cacheTransmitClock;
		clkEnable = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(cacheTransmitClock, t0);
		clkEnable = 1'b1;
		@(negedge clk_sys);
		chk(cacheTransmitClock, !t0);
		cacheDataIn = 32'h1234_5678;
		cacheReceiveClock = 1'b1;
		repeat (2) @(negedge clk_sys);
		cacheReceiveClock = 1'b0;
		access(1, 1'b0, MCAP, 32'h0000_0000);
		chk(rd, 32'h1234_5678);
		access(2, 1'b0, IOCAP, 32'h0000_0000);
		chk(rd, 32'h1234_5678);
		access(1, 1'b1, MCTRL, 32'h0000_0000);
		access(1, 1'b0, MCTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		t0 = cacheTransmitClock;
		repeat (2) @(negedge clk_sys);
		chk(cacheTransmitClock, t0);
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{pciBusResetN, processorResetN, xorHold, cacheReceiveClock} = 4'h0;
		clkEnable = 1'b1;
		{cfgValid, cfgWrite, cfgDevice, memValid, memWrite, ioValid, ioWrite} = 7'h00;
		{cfgOffset, ioAddr} = 24'h00_0000;
		{strapValue, cfgWriteData, memAddr, memWriteData} = 128'h0;
		{ioWriteData, cacheDataIn} = 64'h0;
		fails = 0;
		cmp_count = 0;
		cycles = 0;
		test_freq();
		test_queue();
		test_xor();
		test_regs();
		test_clocks();
		print_verdict();
	end
endmodule
